// ### hw/timer8_regs.svh
// Register offsets, field positions and constants of the timer block
`ifndef TIMER8_REGS_SVH
`define TIMER8_REGS_SVH
// Register byte offsets
`define T8_OFF_CTRL   8'h00
`define T8_OFF_FORCE  8'h04
`define T8_OFF_COUNT  8'h08
`define T8_OFF_CMP_A  8'h0C
`define T8_OFF_CMP_B  8'h10
`define T8_OFF_FLAGS  8'h14
`define T8_OFF_IRQEN  8'h18
`define T8_OFF_PIN    8'h1C
// Field positions
`define T8_F_WGM      2:0
`define T8_F_COMA     5:4
`define T8_F_COMB     7:6
`define T8_F_CS       10:8
`define T8_F_FLG      2:0
`define T8_F_PVAL     1:0
`define T8_F_PDIR     3:2
`define T8_F_OCS      5:4
`define T8_F_BYTE     7:0
`define T8_F_LADDR    7:0
`define T8_B_FA       0
`define T8_B_FB       1
`define T8_B_PWM      0
`define T8_B_OVF      0
// Mode codes and counter limits
`define T8_WGM_NORMAL 3'h0
`define T8_WGM_CTC    3'h2
`define T8_CS_STOP    3'h0
`define T8_COM_OFF    2'h0
`define T8_CNT_MAX    8'hFF
`define T8_CNT_BOTTOM 8'h00
`define T8_HSIZE_WORD 3'h2
`define T8_READY_RST  1'b1
`endif

// ### hw/timer8_pkg.sv
// Types shared by the timer compare block
package timer8_pkg;

    // Compare output mode actions
    typedef enum logic [1:0] {
        com_none,
        com_toggle,
        com_clear,
        com_set
    } com_e;

    // State of one compare channel
    typedef struct packed {
        logic [7:0] buffer;
        logic [7:0] active;
        logic       oc;
        logic       hit;
    } chan_s;

    // State of the top level
    typedef struct packed {
        logic [7:0]  count;
        logic [2:0]  wgm;
        logic [1:0]  com_a;
        logic [1:0]  com_b;
        logic [2:0]  cs;
        logic [2:0]  flags;
        logic [2:0]  irq_en;
        logic [1:0]  port_val;
        logic [1:0]  port_dir;
        logic        blocked;
        logic        dp_valid;
        logic        dp_wr;
        logic [7:0]  dp_addr;
        logic [31:0] rdata;
        logic [1:0]  pin_out;
        logic [1:0]  pin_oe;
        logic [2:0]  irq;
        logic        ready;
        logic        resp;
    } top_s;

endpackage : timer8_pkg

// ### hw/timer8_compare_channel.sv
// One compare channel: compare value, match and output state
`timescale 1ns/1ps
`include "timer8_regs.svh"
module timer8_compare_channel (
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Counter view
    input  wire logic [7:0] count,
    input  wire logic       tick,
    input  wire logic       blocked,
    input  wire logic       at_bottom,
    // Mode and strobes
    input  wire logic       pwm,
    input  wire logic [1:0] com,
    input  wire logic       force_strobe,
    input  wire logic       cmp_wr,
    input  wire logic [7:0] cmp_wdata,
    // Results
    output var  logic       match_now,
    output var  logic       match_event,
    output var  logic       flag_set,
    output var  logic       oc,
    output var  logic [7:0] cmp_read
);
    timer8_pkg::chan_s st_reg;
    timer8_pkg::chan_s st_next;
    timer8_pkg::com_e  com_mode;

    // Comparator and qualified match
    assign com_mode    = timer8_pkg::com_e'(com);
    assign match_now   = count == st_reg.active;
    assign match_event = tick && match_now && !blocked;
    assign flag_set    = st_reg.hit;
    assign oc          = st_reg.oc;
    assign cmp_read    = st_next.buffer;

    // Next state of the channel
    always_comb begin
        st_next = st_reg;
        st_next.hit = match_event;
        if (cmp_wr) begin
            st_next.buffer = cmp_wdata;
        end
        if (!pwm && cmp_wr) begin
            st_next.active = cmp_wdata;
        end else if (pwm && at_bottom) begin
            st_next.active = st_reg.buffer;
        end
        if (match_event || (force_strobe && !pwm)) begin
            case (com_mode)
                timer8_pkg::com_toggle: st_next.oc = !st_reg.oc;
                timer8_pkg::com_clear:  st_next.oc = 1'b0;
                timer8_pkg::com_set:    st_next.oc = 1'b1;
                default:                st_next.oc = st_reg.oc;
            endcase
        end else if (pwm && at_bottom
                     && st_reg.active != `T8_CNT_MAX) begin
            case (com_mode)
                timer8_pkg::com_clear: st_next.oc = 1'b1;
                timer8_pkg::com_set:   st_next.oc = 1'b0;
                default:               st_next.oc = st_reg.oc;
            endcase
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_flag_delay: assert property (match_event |=> flag_set)
        else $error("match flag not raised after match");
    chk_force_noflag: assert property (
        force_strobe && !match_event |=> !flag_set)
        else $error("force strobe raised the match flag");
    chk_direct_load: assert property (
        cmp_wr && !pwm |=> st_reg.active == $past(cmp_wdata))
        else $error("compare value not loaded directly");
    chk_buffer_hold: assert property (
        pwm && !at_bottom |=> $stable(st_reg.active))
        else $error("active compare changed off bottom");
    chk_toggle_act: assert property (
        match_event && com == 2'h1 |=> oc != $past(oc))
        else $error("toggle mode did not toggle");
    chk_oc_idle: assert property (
        !match_event && !at_bottom && !force_strobe |=> $stable(oc))
        else $error("output state moved without cause");
    chk_com_zero: assert property (
        com == `T8_COM_OFF |=> $stable(oc))
        else $error("output state moved with mode zero");

endmodule : timer8_compare_channel

// ### hw/timer8_output_compare_unit.sv
// Timer compare block: bus registers, counter and compare pins
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "timer8_regs.svh"
module timer8_output_compare_unit (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // Interrupt service
    input  wire logic [2:0]  int_ack,
    output var  logic [2:0]  int_req,
    // Compare pins
    output var  logic [1:0]  oc_pin_out,
    output var  logic [1:0]  oc_pin_oe
);

    //------------------------------------------------
    // Declarations
    //------------------------------------------------
    timer8_pkg::top_s st_reg;
    timer8_pkg::top_s st_next;

    logic        tick;
    logic        clear_on_match_mode;
    logic        pwm;
    logic        bus_wr;
    logic        wr_count;
    logic        wr_flags;
    logic        wr_force;
    logic        cnt_clear;
    logic        ovf_evt;
    logic        at_bottom;
    logic        addr_take;
    logic [2:0]  flag_set;
    logic [2:0]  flag_clr;
    logic [3:0]  com_pair;
    logic [1:0]  chan_event;
    logic [1:0]  chan_hit;
    logic [1:0]  chan_oc;
    logic [1:0]  chan_force;
    logic [1:0]  chan_cmp_wr;
    logic [7:0]  chan_read [2];
    logic [31:0] rd_word;

    //------------------------------------------------
    // Decode of the data phase
    //------------------------------------------------

    // Bus writes taken in the data phase
    assign bus_wr   = st_reg.dp_valid && st_reg.dp_wr;
    assign wr_count = bus_wr
                      && st_reg.dp_addr == `T8_OFF_COUNT;
    assign wr_flags = bus_wr
                      && st_reg.dp_addr == `T8_OFF_FLAGS;
    assign wr_force = bus_wr
                      && st_reg.dp_addr == `T8_OFF_FORCE;
    assign chan_cmp_wr[0] = bus_wr
                      && st_reg.dp_addr == `T8_OFF_CMP_A;
    assign chan_cmp_wr[1] = bus_wr
                      && st_reg.dp_addr == `T8_OFF_CMP_B;
    assign chan_force[0] = wr_force && hwdata[`T8_B_FA];
    assign chan_force[1] = wr_force && hwdata[`T8_B_FB];

    //------------------------------------------------
    // Counter control
    //------------------------------------------------

    assign tick = st_reg.cs != `T8_CS_STOP;
    assign clear_on_match_mode  = st_reg.wgm == `T8_WGM_CTC;
    assign pwm  = st_reg.wgm[`T8_B_PWM];
    assign com_pair = {st_reg.com_b, st_reg.com_a};

    assign cnt_clear = tick && clear_on_match_mode && chan_event[0];
    assign ovf_evt   = tick && !wr_count
                       && st_reg.count == `T8_CNT_MAX;
    assign at_bottom = tick && !wr_count
                       && (cnt_clear
                           || st_reg.count == `T8_CNT_MAX);

    // Flag set and clear requests
    assign flag_set = {chan_hit, ovf_evt};
    assign flag_clr = int_ack
                      | (wr_flags ? hwdata[`T8_F_FLG] : 3'h0);

    //------------------------------------------------
    // Compare channels
    //------------------------------------------------
    generate
        for (genvar i = 0; i < 2; i++) begin : g_chan
            timer8_compare_channel u_chan (
                .hclk         (hclk),
                .hresetn      (hresetn),
                .count        (st_reg.count),
                .tick         (tick),
                .blocked      (st_reg.blocked),
                .at_bottom    (at_bottom),
                .pwm          (pwm),
                .com          (com_pair[i*2 +: 2]),
                .force_strobe (chan_force[i]),
                .cmp_wr       (chan_cmp_wr[i]),
                .cmp_wdata    (hwdata[`T8_F_BYTE]),
                .match_now    (),
                .match_event  (chan_event[i]),
                .flag_set     (chan_hit[i]),
                .oc           (chan_oc[i]),
                .cmp_read     (chan_read[i])
            );
        end
    endgenerate

    //------------------------------------------------
    // Next state
    //------------------------------------------------

    // Counter, registers, pins and bus answer
    always_comb begin
        st_next = st_reg;
        rd_word = 32'h0000_0000;
        if (wr_count) begin
            st_next.count = hwdata[`T8_F_BYTE];
        end else if (cnt_clear) begin
            st_next.count = `T8_CNT_BOTTOM;
        end else if (tick) begin
            st_next.count = st_reg.count + 8'h01;
        end
        if (wr_count) begin
            st_next.blocked = 1'b1;
        end else if (tick) begin
            st_next.blocked = 1'b0;
        end
        if (bus_wr && st_reg.dp_addr == `T8_OFF_CTRL) begin
            st_next.wgm   = hwdata[`T8_F_WGM];
            st_next.com_a = hwdata[`T8_F_COMA];
            st_next.com_b = hwdata[`T8_F_COMB];
            st_next.cs    = hwdata[`T8_F_CS];
        end
        if (bus_wr && st_reg.dp_addr == `T8_OFF_IRQEN) begin
            st_next.irq_en = hwdata[`T8_F_FLG];
        end
        if (bus_wr && st_reg.dp_addr == `T8_OFF_PIN) begin
            st_next.port_val = hwdata[`T8_F_PVAL];
            st_next.port_dir = hwdata[`T8_F_PDIR];
        end
        st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;
        st_next.irq = st_next.flags & st_next.irq_en;
        for (int i = 0; i < 2; i++) begin
            if (com_pair[i*2 +: 2] != `T8_COM_OFF) begin
                st_next.pin_out[i] = chan_oc[i];
            end else begin
                st_next.pin_out[i] = st_reg.port_val[i];
            end
            st_next.pin_oe[i] = st_reg.port_dir[i];
        end
        // Read mux shows the state after this edge, except the output states, which it shows from before the edge
        case (haddr[`T8_F_LADDR])
            `T8_OFF_CTRL: begin
                rd_word[`T8_F_WGM]  = st_next.wgm;
                rd_word[`T8_F_COMA] = st_next.com_a;
                rd_word[`T8_F_COMB] = st_next.com_b;
                rd_word[`T8_F_CS]   = st_next.cs;
            end
            `T8_OFF_COUNT: begin
                rd_word[`T8_F_BYTE] = st_next.count;
            end
            `T8_OFF_CMP_A: begin
                rd_word[`T8_F_BYTE] = chan_read[0];
            end
            `T8_OFF_CMP_B: begin
                rd_word[`T8_F_BYTE] = chan_read[1];
            end
            `T8_OFF_FLAGS: begin
                rd_word[`T8_F_FLG] = st_next.flags;
            end
            `T8_OFF_IRQEN: begin
                rd_word[`T8_F_FLG] = st_next.irq_en;
            end
            `T8_OFF_PIN: begin
                rd_word[`T8_F_PVAL] = st_next.port_val;
                rd_word[`T8_F_PDIR] = st_next.port_dir;
                rd_word[`T8_F_OCS]  = chan_oc;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
        // Address phase capture, zero wait states
        st_next.ready = 1'b1;
        st_next.resp  = 1'b0;
        if (addr_take) begin
            st_next.dp_valid = hsize == `T8_HSIZE_WORD;
            st_next.dp_wr    = hwrite;
            st_next.dp_addr  = haddr[`T8_F_LADDR];
            st_next.rdata    = hwrite ? 32'h0000_0000 : rd_word;
        end else begin
            st_next.dp_valid = 1'b0;
            st_next.dp_wr    = 1'b0;
        end
    end

    // Transfer accepted in the address phase
    assign addr_take = hsel && htrans[1] && hready;

    //------------------------------------------------
    // State register and outputs
    //------------------------------------------------

    // All state in one register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg       <= '0;
            st_reg.ready <= `T8_READY_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the register
    assign hrdata     = st_reg.rdata;
    assign hreadyout  = st_reg.ready;
    assign hresp      = st_reg.resp;
    assign int_req    = st_reg.irq;
    assign oc_pin_out = st_reg.pin_out;
    assign oc_pin_oe  = st_reg.pin_oe;

    //------------------------------------------------
    // Checks
    //------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Count write then a timer tick in the next cycle
    sequence s_cnt_write;
        wr_count ##1 tick;
    endsequence

    property p_write_block;
        s_cnt_write |-> chan_event == 2'b00;
    endproperty

    chk_write_block: assert property (p_write_block)
        else $error("match seen right after count write");

    chk_cpu_priority: assert property (
        wr_count
        |=> st_reg.count == $past(hwdata[`T8_F_BYTE]))
        else $error("count write lost to counting");

    chk_normal_wrap: assert property (
        tick && !wr_count
        && st_reg.wgm == `T8_WGM_NORMAL
        |=> st_reg.count == 8'($past(st_reg.count) + 8'h01))
        else $error("normal mode did not increment");

    chk_ovf_set: assert property (
        ovf_evt
        |=> st_reg.flags[`T8_B_OVF]
            && st_reg.count == `T8_CNT_BOTTOM)
        else $error("overflow flag not set at zero");

    chk_ctc_clear: assert property (
        cnt_clear && !wr_count
        |=> st_reg.count == `T8_CNT_BOTTOM)
        else $error("count not cleared on channel A match");

    chk_count_stop: assert property (
        !tick && !wr_count |=> $stable(st_reg.count))
        else $error("count moved while stopped");

    chk_set_wins: assert property (
        flag_set[1] && flag_clr[1] |=> st_reg.flags[1])
        else $error("flag clear beat a set");

    chk_flag_clear: assert property (
        flag_clr[2] && !flag_set[2] |=> !st_reg.flags[2])
        else $error("flag not cleared");

    chk_pin_override: assert property (
        st_reg.com_a != `T8_COM_OFF
        |=> oc_pin_out[0] == $past(chan_oc[0]))
        else $error("pin not overridden by output state");

    chk_pin_port: assert property (
        st_reg.com_b == `T8_COM_OFF
        |=> oc_pin_out[1] == $past(st_reg.port_val[1]))
        else $error("pin not driven from port value");

    chk_pin_dir: assert property (
        !st_reg.port_dir[0] ##1 !st_reg.port_dir[0]
        |-> !oc_pin_oe[0])
        else $error("pin driven while direction is input");

    chk_irq_req: assert property (
        st_reg.flags[1] && st_reg.irq_en[1]
        && !flag_clr[1]
        && !(bus_wr && st_reg.dp_addr == `T8_OFF_IRQEN)
        |=> int_req[1])
        else $error("enabled flag raised no request");

endmodule : timer8_output_compare_unit

// ### verif/test_timer8_output_compare_unit.sv
// Self-checking bench for the timer compare block
`timescale 1ns/1ps
`include "timer8_regs.svh"
module test_timer8_output_compare_unit;
    // ------------
    // Signals
    // ------------
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [2:0]  int_ack = 3'h0;
    logic [2:0]  int_req;
    logic [1:0]  oc_pin_out;
    logic [1:0]  oc_pin_oe;
    logic [31:0] rd;
    logic [31:0] v;
    logic [7:0]  c;
    logic [7:0]  k;
    integer      seed = 32'hCB62;
    integer      fails = 0;
    integer      samples_checked = 0;
    integer      cycles = 0;

    // Clock and hang guard
    always #20 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fails = fails + 1;
            results();
        end
    end

    timer8_output_compare_unit dut (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .int_ack   (int_ack),
        .int_req   (int_req),
        .oc_pin_out(oc_pin_out),
        .oc_pin_oe (oc_pin_oe)
    );

    // ------------
    // Helpers
    // ------------
    // Compares a seen value with the expected one
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One single AHB-Lite transfer, waits on hready in both phases
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rdr

    // Control word from mode, output modes and clock select
    function automatic logic [31:0] ctrl(input logic [2:0] wgm,
        input logic [1:0] ca, input logic [1:0] cb, input logic [2:0] cs);
        return {21'h0, cs, cb, ca, 1'b0, wgm};
    endfunction : ctrl

    // Pin value: output state when output mode nonzero, else port value
    function automatic logic [1:0] pin_exp(input logic [1:0] ca,
        input logic [1:0] cb, input logic [1:0] pv, input logic [1:0] os);
        return {(cb != 2'h0) ? os[1] : pv[1], (ca != 2'h0) ? os[0] : pv[0]};
    endfunction : pin_exp

    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // ------------
    // Scenarios
    // ------------
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rdr(`T8_OFF_CTRL);
        check("ctrl_reset", rd, 32'h0);
        rdr(8'h40);
        check("unmapped", rd, 32'h0);
        // Force strobe with set, clear, toggle, none: expected 1,0,1,1
        for (int i = 0; i < 4; i++) begin
            wr(`T8_OFF_CTRL, ctrl(3'h0, 2'(3 - i), 2'h0, 3'h0));
            wr(`T8_OFF_FORCE, 32'h1);
            rdr(`T8_OFF_PIN);
            k = 8'(4'hD >> i);
            check("force_state", 32'(rd[4]), 32'(k[0]));
        end
        rdr(`T8_OFF_FLAGS);
        check("force_noflag", rd, 32'h0);
        // output state set by force before the pin is driven
        // Pin override and direction, state A=1 B=0
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(`T8_OFF_CTRL, ctrl(3'h0, {1'b0, i[0]}, {1'b0, i[1]}, 3'h0));
            wr(`T8_OFF_PIN, {28'h0, v[3:0]});
            repeat (2) @(posedge hclk);
            check("pin_oe", {30'h0, oc_pin_oe}, {30'h0, v[3:2]});
            check("pin_out", {30'h0, oc_pin_out & v[3:2]}, {30'h0, v[3:2] &
                pin_exp({1'b0, i[0]}, {1'b0, i[1]}, v[1:0], 2'b01)});
        end
        // Match on A (toggle) and B (none) in Normal mode
        c = {1'b0, 7'($random(seed))} + 8'h10;
        k = 8'h3 + 8'($random(seed) & 3);
        // count written away from both compare values
        wr(`T8_OFF_COUNT, {24'h0, c});
        rdr(`T8_OFF_COUNT);
        check("count_rw_stopped", rd, {24'h0, c});
        wr(`T8_OFF_CMP_A, {24'h0, c + k});
        wr(`T8_OFF_CMP_B, {24'h0, c + k + 8'h1});
        wr(`T8_OFF_CTRL, ctrl(3'h0, 2'h1, 2'h0, 3'h1));
        repeat (20) @(posedge hclk);
        wr(`T8_OFF_CTRL, ctrl(3'h0, 2'h1, 2'h0, 3'h0));
        rdr(`T8_OFF_CMP_A);
        check("cmp_direct", rd, {24'h0, c + k});
        rdr(`T8_OFF_FLAGS);
        check("match_flags", rd, 32'h6);
        rdr(`T8_OFF_PIN);
        check("match_state", {30'h0, rd[5:4]}, 32'h0);
        // Interrupt request, service and write-one clear
        wr(`T8_OFF_IRQEN, 32'h7);
        repeat (2) @(posedge hclk);
        check("int_req", {29'h0, int_req}, 32'h6);
        @(posedge hclk);
        int_ack <= 3'h2;
        @(posedge hclk);
        int_ack <= 3'h0;
        rdr(`T8_OFF_FLAGS);
        check("ack_clear", rd, 32'h4);
        wr(`T8_OFF_FLAGS, 32'h4);
        rdr(`T8_OFF_FLAGS);
        check("w1_clear", rd, 32'h0);
        // Wrap from 0xFF to 0x00 sets the overflow flag
        wr(`T8_OFF_COUNT, 32'hFD);
        wr(`T8_OFF_CTRL, ctrl(3'h0, 2'h0, 2'h0, 3'h1));
        repeat (5) @(posedge hclk);
        wr(`T8_OFF_CTRL, ctrl(3'h0, 2'h0, 2'h0, 3'h0));
        rdr(`T8_OFF_FLAGS);
        check("overflow", {31'h0, rd[0]}, 32'h1);
        rdr(`T8_OFF_COUNT);
        check("wrapped", {31'h0, rd < 32'h20}, 32'h1);
        // Count write blocks the match at the next tick
        wr(`T8_OFF_FLAGS, 32'h7);
        wr(`T8_OFF_CMP_B, 32'h40);
        wr(`T8_OFF_COUNT, 32'h40);
        wr(`T8_OFF_CTRL, ctrl(3'h0, 2'h0, 2'h1, 3'h1));
        repeat (10) @(posedge hclk);
        wr(`T8_OFF_CTRL, ctrl(3'h0, 2'h0, 2'h1, 3'h0));
        rdr(`T8_OFF_FLAGS);
        check("blocked_flag", {31'h0, rd[2]}, 32'h0);
        rdr(`T8_OFF_PIN);
        check("blocked_state", {31'h0, rd[5]}, 32'h0);
        // PWM mode: buffered compare, force ignored, state kept
        wr(`T8_OFF_CMP_A, 32'h30);
        wr(`T8_OFF_CTRL, ctrl(3'h1, 2'h1, 2'h0, 3'h0));
        wr(`T8_OFF_FORCE, 32'h1);
        rdr(`T8_OFF_PIN);
        check("pwm_state", {31'h0, rd[4]}, 32'h0);
        wr(`T8_OFF_CMP_A, 32'hA0);
        wr(`T8_OFF_COUNT, 32'h90);
        wr(`T8_OFF_FLAGS, 32'h7);
        wr(`T8_OFF_CTRL, ctrl(3'h1, 2'h1, 2'h0, 3'h1));
        repeat (25) @(posedge hclk);
        wr(`T8_OFF_CTRL, ctrl(3'h1, 2'h1, 2'h0, 3'h0));
        rdr(`T8_OFF_FLAGS);
        check("pwm_buffered", {31'h0, rd[1]}, 32'h0);
        rdr(`T8_OFF_CMP_A);
        check("pwm_readback", rd, 32'hA0);
        // PWM inverted: buffer loads at bottom, clear there, set at match
        wr(`T8_OFF_CMP_A, 32'h05);
        wr(`T8_OFF_COUNT, 32'hFD);
        wr(`T8_OFF_FLAGS, 32'h7);
        wr(`T8_OFF_CTRL, ctrl(3'h1, 2'h3, 2'h0, 3'h1));
        repeat (10) @(posedge hclk);
        wr(`T8_OFF_CTRL, ctrl(3'h1, 2'h3, 2'h0, 3'h0));
        rdr(`T8_OFF_FLAGS);
        check("pwm_bottom_load", rd, 32'h3);
        rdr(`T8_OFF_PIN);
        check("pwm_inverted", {31'h0, rd[4]}, 32'h1);
        // Clear-on-match: count never passes channel A, no overflow
        wr(`T8_OFF_CTRL, ctrl(3'h0, 2'h0, 2'h0, 3'h0));
        k = 8'h4 + 8'($random(seed) & 7);
        wr(`T8_OFF_CMP_A, {24'h0, k});
        wr(`T8_OFF_COUNT, 32'h0);
        wr(`T8_OFF_FLAGS, 32'h7);
        wr(`T8_OFF_CTRL, ctrl(3'h2, 2'h1, 2'h0, 3'h1));
        repeat (40) @(posedge hclk);
        wr(`T8_OFF_CTRL, ctrl(3'h2, 2'h1, 2'h0, 3'h0));
        rdr(`T8_OFF_COUNT);
        check("ctc_top", {31'h0, rd <= {24'h0, k}}, 32'h1);
        rdr(`T8_OFF_FLAGS);
        check("ctc_flags", rd, 32'h2);
        results();
    end
endmodule : test_timer8_output_compare_unit
